// [inc/cpaf_pkg.sv]
/*
  constants for the contactless polling / anticollision receive block:
  register offsets, field positions, reset values, protocol bytes.
  assumes a 40 MHz system clock and a 32-bit apb register bus.
*/
package cpaf_pkg;
  // ----------------------------------------------------------------
  // register map (byte addresses)
  // ----------------------------------------------------------------
  localparam logic [7:0] REG_CTRL = 8'h00;
  localparam logic [7:0] REG_STATUS = 8'h04;
  localparam logic [7:0] REG_ERROR = 8'h08;
  localparam logic [7:0] REG_FIFO_DATA = 8'h0c;
  localparam logic [7:0] REG_FIFO_LEVEL = 8'h10;
  localparam logic [7:0] REG_SYS_CODE = 8'h14;
  localparam logic [7:0] REG_SLOTS = 8'h18;
  localparam logic [7:0] REG_RESP = 8'h1c;
  // ----------------------------------------------------------------
  // field positions
  // ----------------------------------------------------------------
  localparam int CTRL_CONT_RX = 0;
  localparam int CTRL_AUTO_ANTICOLLISION_COMMAND = 1;
  localparam int CTRL_MODE_DET_DIS = 2;
  localparam int CTRL_TMR_LAST = 3;
  localparam int CTRL_SOFT_PD = 4;
  localparam int CTRL_AMP_EN = 5;
  localparam int CTRL_RX_START = 6;
  localparam int CTRL_TMR_START = 7;
  localparam int CTRL_THR_LSB = 8;
  localparam int ERR_OVFL = 0;
  localparam int ERR_PKT = 1;
  localparam int LEVEL_FLUSH = 7;
  localparam int EINFO_CRC_ERR = 0;
  localparam int EINFO_OVFL = 1;
  // ----------------------------------------------------------------
  // fifo and protocol
  // ----------------------------------------------------------------
  localparam int FIFO_DEPTH = 64;
  localparam int FIFO_AW = 6;
  localparam logic [7:0] POLL_CMD = 8'h00;
  localparam logic [7:0] SC_WILDCARD = 8'hff;
  localparam logic [2:0] IDX_CMD = 3'h1;
  localparam logic [2:0] IDX_SC_HI = 3'h2;
  localparam logic [2:0] IDX_SC_LO = 3'h3;
  localparam logic [2:0] IDX_TSN = 3'h5;
  localparam logic [2:0] IDX_MAX = 3'h7;
  localparam logic [1:0] RATE_RSVD = 2'h3;
  localparam logic [15:0] LFSR_SEED = 16'hace1;
  localparam logic [15:0] LFSR_TAPS = 16'hb400;
  // ----------------------------------------------------------------
  // timing
  // ----------------------------------------------------------------
  localparam int CLK_PERIOD_NS = 25;
  localparam int SLOT_TIME_NS = 1208000;
  localparam int SLOT_CYCLES = SLOT_TIME_NS / CLK_PERIOD_NS;
endpackage

// [rtl/cpaf_fifo_mem.sv]
/*
  byte storage behind the shared receive fifo, one write and one read port.
  assumes the caller owns the pointers; read data comes from a register.
*/
`timescale 1ns/1ps
module cpaf_fifo_mem #(
  parameter int DW = 8,
  parameter int DEPTH = 64,
  parameter int AW = 6
) (
  input wire logic sys_clk_in,
  input wire logic ce_in,
  input wire logic wr_en_in,
  input wire logic [AW-1:0] wr_addr_in,
  input wire logic [DW-1:0] wr_data_in,
  input wire logic rd_en_in,
  input wire logic [AW-1:0] rd_addr_in,
  output logic [DW-1:0] rd_data_out
);
  logic [DW-1:0] mem_q [DEPTH];

  always_ff @(posedge sys_clk_in) begin
    if (ce_in && wr_en_in) begin
      mem_q[wr_addr_in] <= wr_data_in;
    end
    if (ce_in && rd_en_in) begin
      rd_data_out <= mem_q[rd_addr_in];
    end
  end
endmodule

// [rtl/cpaf_top.sv]
/*
  polling receive path, target auto-anticollision, data mode detector,
  field level detector and polling timeslot timer, with an apb slave.
  assumes byte strobes from the demodulator and level codes from the
  field comparator, all synchronous to sys_clk_in.
*/
// Behaviour
// - timer event every slot or last only
// - continuous receive rearms after every packet
// - error-info byte appended after each stored packet
// - first stored byte is length byte
// - fifo 64 bytes holds three packets
// - byte into full fifo dropped, overflow set
// - auto answering only while anticollision runs
// - random response slot from zero to count
// - answer only on matching system code
// - received ff byte matches any byte
// - mismatch sends no answer
// - other command stops anticollision, stored
// - mode detector locks scheme and rate
// - detector runs in anticollision, field-loss resets
// - disable bit turns detector off
// - 4-bit threshold, high code less sensitive
// - field detection wakes and signals
// - amplifier enable, off in soft power-down
`timescale 1ns/1ps
module cpaf_top
  import cpaf_pkg::*;
#(
  parameter int SLOT_CYC = SLOT_CYCLES,
  parameter int DEPTH = FIFO_DEPTH
) (
  input wire logic sys_clk_in,
  input wire logic rst_in,
  input wire logic ce_in,
  input wire logic [7:0] paddr_in,
  input wire logic psel_in,
  input wire logic penable_in,
  input wire logic pwrite_in,
  input wire logic [31:0] pwdata_in,
  output logic [31:0] prdata_out,
  output logic pready_out,
  output logic pslverr_out,
  input wire logic rx_byte_valid_in,
  input wire logic [7:0] rx_byte_in,
  input wire logic rx_end_in,
  input wire logic rx_crc_ok_in,
  output logic rx_armed_out,
  input wire logic det_valid_in,
  input wire logic [1:0] det_scheme_in,
  input wire logic [1:0] det_rate_in,
  output logic mode_det_active_out,
  output logic mode_locked_out,
  output logic [1:0] rx_scheme_out,
  output logic [1:0] rx_rate_out,
  input wire logic [3:0] rf_level_in,
  output logic field_present_out,
  output logic field_wake_out,
  output logic amp_on_out,
  output logic auto_anticollision_command_active_out,
  output logic resp_req_out,
  output logic [7:0] resp_slot_out,
  output logic timer_event_out,
  output logic timer_running_out
);
  typedef struct packed {
    logic cont_rx;
    logic auto_anticollision_command;
    logic mode_det_dis;
    logic tmr_last;
    logic soft_pd;
    logic amp_en;
    logic amp_on;
    logic [3:0] thr;
    logic [15:0] sys_code;
    logic [7:0] slot_total;
    logic rx_armed;
    logic rx_busy;
    logic [2:0] idx;
    logic [7:0] cmd;
    logic [7:0] sc_hi;
    logic [7:0] sc_lo;
    logic [7:0] timeslot_count;
    logic ovfl;
    logic pkt_err;
    logic pkt_ovfl;
    logic [6:0] wptr;
    logic [6:0] rptr;
    logic [6:0] pkt_wptr;
    logic [15:0] lfsr;
    logic resp_req;
    logic [7:0] resp_slot;
    logic det_lock;
    logic [1:0] det_scheme;
    logic [1:0] det_rate;
    logic field;
    logic wake;
    logic tmr_run;
    logic [31:0] tmr_cnt;
    logic [7:0] tmr_slot;
    logic tmr_evt;
    logic [31:0] prdata;
    logic data_rd;
  } cpaf_state_t;

  cpaf_state_t s_q;
  cpaf_state_t s_d;
  logic wr_en;
  logic [7:0] wr_data;
  logic [5:0] wr_addr;
  logic rd_en;
  logic [7:0] mem_rdata;
  logic [6:0] level;
  logic full;
  logic hit;
  logic setup_rd;
  logic acc_wr;
  logic acc_done;
  logic sc_match;
  logic [16:0] slot_prod;
  logic [7:0] einfo;

  // ----------------------------------------------------------------
  // apb decode
  // ----------------------------------------------------------------
  always_comb begin
    case (paddr_in)
      REG_CTRL, REG_STATUS, REG_ERROR, REG_FIFO_DATA: hit = 1'b1;
      REG_FIFO_LEVEL, REG_SYS_CODE, REG_SLOTS, REG_RESP: hit = 1'b1;
      default: hit = 1'b0;
    endcase
  end

  // zero wait states: read data is captured in the setup cycle
  assign pready_out = 1'b1;
  assign pslverr_out = psel_in & penable_in & ~hit;
  assign setup_rd = psel_in & ~penable_in & ~pwrite_in;
  assign acc_done = psel_in & penable_in & hit;
  assign acc_wr = acc_done & pwrite_in;
  assign rd_en = setup_rd & (paddr_in == REG_FIFO_DATA);
  // host-visible fill from registered pointers, free of same-cycle writes
  assign level = s_q.wptr - s_q.rptr;
  assign prdata_out = s_q.data_rd ? {24'h000000, mem_rdata} : s_q.prdata;

  // ----------------------------------------------------------------
  // fifo storage
  // ----------------------------------------------------------------
  cpaf_fifo_mem #(
    .DW(8),
    .DEPTH(DEPTH),
    .AW(FIFO_AW)
  ) u_mem (
    .sys_clk_in(sys_clk_in),
    .ce_in(ce_in),
    .wr_en_in(wr_en),
    .wr_addr_in(wr_addr),
    .wr_data_in(wr_data),
    .rd_en_in(rd_en),
    .rd_addr_in(s_q.rptr[5:0]),
    .rd_data_out(mem_rdata)
  );

  assign sc_match = (s_q.sc_hi == SC_WILDCARD || s_q.sc_hi == s_q.sys_code[15:8]) &&
                    (s_q.sc_lo == SC_WILDCARD || s_q.sc_lo == s_q.sys_code[7:0]);
  assign slot_prod = 17'(s_q.lfsr[7:0]) * 17'({1'b0, s_q.timeslot_count} + 9'h001);
  assign einfo = 8'(((s_q.pkt_ovfl ? 1 : 0) << EINFO_OVFL) | ((rx_crc_ok_in ? 0 : 1) << EINFO_CRC_ERR));

  // ----------------------------------------------------------------
  // next state
  // ----------------------------------------------------------------
  always_comb begin
    s_d = s_q;
    wr_en = 1'b0;
    wr_data = rx_byte_in;
    s_d.resp_req = 1'b0;
    s_d.tmr_evt = 1'b0;
    s_d.data_rd = 1'b0;
    s_d.lfsr = s_q.lfsr[0] ? ((s_q.lfsr >> 1) ^ LFSR_TAPS) : (s_q.lfsr >> 1);
    // register writes
    if (acc_wr) begin
      case (paddr_in)
        REG_CTRL: begin
          s_d.cont_rx = pwdata_in[CTRL_CONT_RX];
          s_d.auto_anticollision_command = pwdata_in[CTRL_AUTO_ANTICOLLISION_COMMAND];
          s_d.mode_det_dis = pwdata_in[CTRL_MODE_DET_DIS];
          s_d.tmr_last = pwdata_in[CTRL_TMR_LAST];
          s_d.soft_pd = pwdata_in[CTRL_SOFT_PD];
          s_d.amp_en = pwdata_in[CTRL_AMP_EN];
          s_d.thr = pwdata_in[CTRL_THR_LSB +: 4];
          if (pwdata_in[CTRL_RX_START] || pwdata_in[CTRL_AUTO_ANTICOLLISION_COMMAND]) begin
            s_d.rx_armed = 1'b1;
          end else if (!s_q.rx_busy && !pwdata_in[CTRL_CONT_RX]) begin
            s_d.rx_armed = 1'b0;
          end
          if (pwdata_in[CTRL_TMR_START]) begin
            s_d.tmr_run = 1'b1;
            s_d.tmr_cnt = 32'h0;
            s_d.tmr_slot = 8'h00;
          end
        end
        REG_ERROR: begin
          if (pwdata_in[ERR_PKT]) begin
            s_d.pkt_err = 1'b0;
          end
        end
        REG_FIFO_LEVEL: begin
          if (pwdata_in[LEVEL_FLUSH]) begin
            s_d.wptr = 7'h00;
            s_d.rptr = 7'h00;
            s_d.pkt_wptr = 7'h00;
            s_d.ovfl = 1'b0;
          end
        end
        REG_SYS_CODE: s_d.sys_code = pwdata_in[15:0];
        REG_SLOTS: s_d.slot_total = pwdata_in[7:0];
        default: ;
      endcase
    end
    // reads: capture in setup, pop on completion
    if (setup_rd) begin
      case (paddr_in)
        REG_CTRL: s_d.prdata = 32'({s_q.thr, 2'h0, s_q.amp_en, s_q.soft_pd, s_q.tmr_last,
                                   s_q.mode_det_dis, s_q.auto_anticollision_command, s_q.cont_rx});
        REG_STATUS: s_d.prdata = 32'({s_q.tmr_run, 2'h0, s_q.det_rate, 1'b0, s_q.det_scheme,
                                     s_q.det_lock, s_q.field, s_q.rx_busy, s_q.rx_armed,
                                     s_q.auto_anticollision_command});
        REG_ERROR: s_d.prdata = 32'({s_q.pkt_err, s_q.ovfl});
        REG_FIFO_LEVEL: s_d.prdata = 32'(level);
        REG_SYS_CODE: s_d.prdata = 32'(s_q.sys_code);
        REG_SLOTS: s_d.prdata = 32'(s_q.slot_total);
        REG_RESP: s_d.prdata = 32'(s_q.resp_slot);
        default: s_d.prdata = 32'h0;
      endcase
      s_d.data_rd = (paddr_in == REG_FIFO_DATA) && (level != 7'h00);
    end
    if (acc_done && !pwrite_in && s_q.data_rd) begin
      s_d.rptr = s_q.rptr + 7'h01;
    end
    // receive path: bytes stream straight into the fifo
    if (s_q.rx_armed && rx_byte_valid_in) begin
      wr_en = 1'b1;
      if (!s_q.rx_busy) begin
        s_d.rx_busy = 1'b1;
        s_d.idx = 3'h0;
        s_d.pkt_wptr = s_d.wptr;
        s_d.pkt_ovfl = 1'b0;
      end else if (s_q.idx != IDX_MAX) begin
        s_d.idx = s_q.idx + 3'h1;
      end
      case (s_q.rx_busy ? s_q.idx + 3'h1 : 3'h0)
        IDX_CMD: s_d.cmd = rx_byte_in;
        IDX_SC_HI: s_d.sc_hi = rx_byte_in;
        IDX_SC_LO: s_d.sc_lo = rx_byte_in;
        IDX_TSN: s_d.timeslot_count = rx_byte_in;
        default: ;
      endcase
    end else if (s_q.rx_busy && rx_end_in) begin
      s_d.rx_busy = 1'b0;
      s_d.rx_armed = s_q.cont_rx | s_q.auto_anticollision_command;
      if (!rx_crc_ok_in) begin
        s_d.pkt_err = 1'b1;
      end
      if (s_q.auto_anticollision_command && (!rx_crc_ok_in || s_q.cmd == POLL_CMD)) begin
        // polling and broken frames are not kept in target mode
        s_d.wptr = s_d.pkt_wptr;
        if (rx_crc_ok_in && sc_match) begin
          s_d.resp_req = 1'b1;
          s_d.resp_slot = slot_prod[15:8];
        end
      end else begin
        wr_en = 1'b1;
        wr_data = einfo;
        if (s_q.auto_anticollision_command) begin
          s_d.auto_anticollision_command = 1'b0;
          s_d.rx_armed = s_q.cont_rx;
        end
      end
    end
    full = (7'(s_d.wptr - s_d.rptr) == 7'(DEPTH));
    if (wr_en && full) begin
      wr_en = 1'b0;
      s_d.ovfl = 1'b1;
      s_d.pkt_ovfl = 1'b1;
    end else if (wr_en) begin
      s_d.wptr = s_d.wptr + 7'h01;
    end
    wr_addr = s_q.wptr == s_d.wptr ? s_d.wptr[5:0] : s_d.wptr[5:0] - 6'h01;
    // field level detector
    s_d.field = rf_level_in >= s_q.thr;
    s_d.wake = s_d.field & ~s_q.field;
    s_d.amp_on = s_d.amp_en & ~s_d.soft_pd;
    // data mode detector
    if (!s_q.field) begin
      s_d.det_lock = 1'b0;
    end else if (s_q.auto_anticollision_command && !s_q.mode_det_dis && det_valid_in &&
                 det_rate_in != RATE_RSVD) begin
      s_d.det_lock = 1'b1;
      s_d.det_scheme = det_scheme_in;
      s_d.det_rate = det_rate_in;
    end
    // polling timeslot timer
    if (s_q.tmr_run) begin
      if (s_q.tmr_cnt == 32'(SLOT_CYC - 1)) begin
        s_d.tmr_cnt = 32'h0;
        s_d.tmr_evt = !s_q.tmr_last || s_q.tmr_slot == s_q.slot_total;
        if (s_q.tmr_slot == s_q.slot_total) begin
          s_d.tmr_run = 1'b0;
        end else begin
          s_d.tmr_slot = s_q.tmr_slot + 8'h01;
        end
      end else begin
        s_d.tmr_cnt = s_q.tmr_cnt + 32'h1;
      end
    end
  end

  // ----------------------------------------------------------------
  // state register
  // ----------------------------------------------------------------
  always_ff @(posedge sys_clk_in) begin
    if (rst_in) begin
      s_q <= '0;
      s_q.lfsr <= LFSR_SEED;
    end else if (ce_in) begin
      s_q <= s_d;
    end
  end

  assign rx_armed_out = s_q.rx_armed;
  assign mode_det_active_out = s_q.auto_anticollision_command & ~s_q.mode_det_dis;
  assign mode_locked_out = s_q.det_lock;
  assign rx_scheme_out = s_q.det_scheme;
  assign rx_rate_out = s_q.det_rate;
  assign field_present_out = s_q.field;
  assign field_wake_out = s_q.wake;
  assign amp_on_out = s_q.amp_on;
  assign auto_anticollision_command_active_out = s_q.auto_anticollision_command;
  assign resp_req_out = s_q.resp_req;
  assign resp_slot_out = s_q.resp_slot;
  assign timer_event_out = s_q.tmr_evt;
  assign timer_running_out = s_q.tmr_run;

  // ----------------------------------------------------------------
  // checks
  // ----------------------------------------------------------------
  default clocking cb @(posedge sys_clk_in); endclocking
  default disable iff (rst_in);

  sequence seq_pkt_end;
    ce_in && s_q.rx_busy && !rx_byte_valid_in && rx_end_in;
  endsequence
  sequence seq_nonpoll_end;
    seq_pkt_end and (s_q.auto_anticollision_command && rx_crc_ok_in && s_q.cmd != POLL_CMD);
  endsequence

  a_ovfl_on_full: assert property (ce_in && s_q.rx_armed && rx_byte_valid_in && full
    |=> s_q.ovfl && s_q.wptr == $past(s_q.wptr)) else $error("overflow not flagged");
  a_einfo_append: assert property (seq_pkt_end and !s_q.auto_anticollision_command
    |-> wr_en == !full && wr_data == einfo) else $error("error-info byte missing");
  a_first_len: assert property (ce_in && s_q.rx_armed && !s_q.rx_busy && rx_byte_valid_in
    && !full |-> wr_en && wr_data == rx_byte_in) else $error("length byte not stored");
  a_cont_rearm: assert property (seq_pkt_end and s_q.cont_rx
    |=> s_q.rx_armed && !s_q.rx_busy) else $error("no rearm after packet");
  a_stop_finish: assert property (ce_in && s_q.rx_busy && !rx_end_in
    |=> s_q.rx_armed) else $error("receiver stopped mid packet");
  a_slot_range: assert property ($rose(s_q.resp_req)
    |-> s_q.resp_slot <= $past(s_q.timeslot_count)) else $error("slot beyond count");
  a_resp_match: assert property (seq_pkt_end and (s_q.auto_anticollision_command && !sc_match)
    |=> !s_q.resp_req) else $error("answer on mismatch");
  a_resp_auto_anticollision_command: assert property (s_q.resp_req |-> $past(s_q.auto_anticollision_command))
    else $error("answer outside anticollision");
  a_nonpoll_stop: assert property (seq_nonpoll_end |=> !s_q.auto_anticollision_command && !s_q.resp_req
    ##0 s_q.wptr != $past(s_q.pkt_wptr) || $past(full)) else $error("anticollision not stopped");
  a_det_reset: assert property (ce_in && !s_q.field |=> !s_q.det_lock)
    else $error("detector kept lock without field");
  a_det_off: assert property (ce_in && s_q.mode_det_dis && !s_q.det_lock
    |=> !s_q.det_lock) else $error("detector ran while disabled");
  a_field_thr: assert property (ce_in |=> s_q.field == ($past(rf_level_in) >= $past(s_q.thr)))
    else $error("field threshold compare wrong");
  a_wake_edge: assert property (s_q.wake |-> s_q.field && $past(!s_q.field))
    else $error("wake without field rise");
  a_amp_pd: assert property (s_q.soft_pd |-> !amp_on_out)
    else $error("amplifier on in power-down");
  a_tmr_last: assert property (s_q.tmr_evt && s_q.tmr_last
    |-> $past(s_q.tmr_slot) == s_q.slot_total && !s_q.tmr_run) else $error("early slot event");
endmodule

// [verif/cpaf_rf_peer.sv]
/*
  remote rf initiator model: sends byte frames on the demodulator strobes.
  assumes the block's sys_clk_in; the frame is loaded before send runs.
*/
`timescale 1ns/1ps
module cpaf_rf_peer (
  input wire logic sys_clk_in,
  output logic rx_byte_valid_out,
  output logic [7:0] rx_byte_out,
  output logic rx_end_out,
  output logic rx_crc_ok_out
);
  // ----------------------------------------------------------------
  // frame store and sender
  // ----------------------------------------------------------------
  logic [7:0] frame [0:31];

  initial begin
    rx_byte_valid_out = 1'b0;
    rx_byte_out = 8'h5a;
    rx_end_out = 1'b0;
    rx_crc_ok_out = 1'b0;
  end

  task automatic load(input int len, input logic [7:0] base);
    frame[0] = 8'(len);
    for (int i = 1; i < len; i++) frame[i] = base + 8'(i);
  endtask

  // gap 0 sends bytes back to back, a slow sender uses larger gaps
  task automatic send(input int len, input logic crc, input int gap);
    for (int i = 0; i < len; i++) begin
      @(posedge sys_clk_in);
      rx_byte_valid_out <= 1'b1;
      rx_byte_out <= frame[i];
      if (gap > 0) begin
        @(posedge sys_clk_in);
        rx_byte_valid_out <= 1'b0;
        rx_byte_out <= ~frame[i];
        repeat (gap - 1) @(posedge sys_clk_in);
      end
    end
    @(posedge sys_clk_in);
    rx_byte_valid_out <= 1'b0;
    rx_byte_out <= ~frame[len-1];
    rx_end_out <= 1'b1;
    rx_crc_ok_out <= crc;
    @(posedge sys_clk_in);
    rx_end_out <= 1'b0;
    // crc line means nothing outside the end strobe
    rx_crc_ok_out <= ~crc;
  endtask
endmodule

// [verif/testbench.sv]
/*
  self-checking bench for the polling receive and anticollision block.
  assumes cpaf_pkg, cpaf_top and the rf peer model are compiled first.
*/
`timescale 1ns/1ps
module testbench;
  import cpaf_pkg::*;
  logic sys_clk_in, rst_in, ce_in, psel_in, penable_in, pwrite_in;
  logic [7:0] paddr_in;
  logic [31:0] pwdata_in, prdata_out;
  logic pready_out, pslverr_out, rx_byte_valid_in, rx_end_in, rx_crc_ok_in;
  logic [7:0] rx_byte_in, resp_slot_out;
  logic rx_armed_out, det_valid_in, mode_det_active_out, mode_locked_out;
  logic [1:0] det_scheme_in, det_rate_in, rx_scheme_out, rx_rate_out;
  logic [3:0] rf_level_in;
  logic field_present_out, field_wake_out, amp_on_out, auto_anticollision_command_active_out;
  logic resp_req_out, timer_event_out, timer_running_out;
  int num_errors = 0;
  int samples_checked = 0;
  logic [31:0] rd;
  logic er;
  int row_len [3] = '{18, 20, 18};
  logic row_crc [3] = '{1'b1, 1'b0, 1'b1};
  logic [15:0] sc_tab [6] = '{16'h1234, 16'h12ff, 16'hff34, 16'hffff, 16'h1235, 16'h5634};

  cpaf_top #(.SLOT_CYC(8), .DEPTH(64)) DUT (.sys_clk_in, .rst_in, .ce_in, .paddr_in,
    .psel_in, .penable_in, .pwrite_in, .pwdata_in, .prdata_out, .pready_out,
    .pslverr_out, .rx_byte_valid_in, .rx_byte_in, .rx_end_in, .rx_crc_ok_in,
    .rx_armed_out, .det_valid_in, .det_scheme_in, .det_rate_in, .mode_det_active_out,
    .mode_locked_out, .rx_scheme_out, .rx_rate_out, .rf_level_in, .field_present_out,
    .field_wake_out, .amp_on_out, .auto_anticollision_command_active_out, .resp_req_out, .resp_slot_out,
    .timer_event_out, .timer_running_out);

  cpaf_rf_peer peer (.sys_clk_in, .rx_byte_valid_out(rx_byte_valid_in),
    .rx_byte_out(rx_byte_in), .rx_end_out(rx_end_in), .rx_crc_ok_out(rx_crc_ok_in));

  initial begin
    sys_clk_in = 1'b0;
    forever #12.5 sys_clk_in = ~sys_clk_in;
  end

  // ----------------------------------------------------------------
  // checking and bus tasks
  // ----------------------------------------------------------------
  task automatic summarize();
    $display("comparisons %0d, mismatches %0d", samples_checked, num_errors);
    if (num_errors == 0 && samples_checked > 0) begin
      $display("Finished cleanly");
    end else begin
      $display("Finished with errors");
    end
    $finish;
  endtask

  task automatic chk(input logic [31:0] seen, input logic [31:0] exp);
    samples_checked++;
    if (seen !== exp) begin
      num_errors++;
      $display("[FAIL] %0t seen %h expected %h", $time, seen, exp);
    end
  endtask

  task automatic apb(input logic w, input logic [7:0] a, input logic [31:0] d);
    int n;
    n = 0;
    @(posedge sys_clk_in);
    psel_in <= 1'b1;
    penable_in <= 1'b0;
    paddr_in <= a;
    pwrite_in <= w;
    pwdata_in <= d;
    @(posedge sys_clk_in);
    penable_in <= 1'b1;
    do begin
      @(posedge sys_clk_in);
      n++;
    end while (pready_out !== 1'b1 && n < 50);
    rd = prdata_out;
    er = pslverr_out;
    psel_in <= 1'b0;
    penable_in <= 1'b0;
    if (pready_out !== 1'b1) begin
      num_errors++;
      summarize();
    end
  endtask

  // looks for the one-cycle answer strobe after a frame end
  task automatic wresp(output int got, output logic [7:0] slot);
    got = 0;
    slot = 8'h00;
    for (int k = 0; k < 20; k++) begin
      #1;
      if (resp_req_out === 1'b1) begin
        got++;
        slot = resp_slot_out;
      end
      @(posedge sys_clk_in);
    end
  endtask

  // ----------------------------------------------------------------
  // main sequence
  // ----------------------------------------------------------------
  initial begin
    int got, cnt;
    logic [7:0] slot;
    logic [31:0] exp;
    rst_in = 1'b1;
    ce_in = 1'b1;
    psel_in = 1'b0;
    penable_in = 1'b0;
    pwrite_in = 1'b0;
    paddr_in = 8'h00;
    pwdata_in = 32'h0;
    det_valid_in = 1'b0;
    det_scheme_in = 2'h0;
    det_rate_in = 2'h0;
    rf_level_in = 4'h0;
    repeat (10) @(posedge sys_clk_in);
    rst_in <= 1'b0;
    #1;
    chk({auto_anticollision_command_active_out, rx_armed_out, timer_running_out, pready_out}, 32'h1);
    apb(1'b0, REG_CTRL, 32'h0);
    chk(rd, 32'h0);
    apb(1'b0, 8'h40, 32'h0);
    chk(er, 32'h1);
    chk(rd, 32'h0);
    // three packets back to back, then one into a nearly full fifo
    apb(1'b1, REG_CTRL, 32'h41);
    for (int r = 0; r < 3; r++) begin
      peer.load(row_len[r], 8'(r * 40));
      peer.send(row_len[r], row_crc[r], r);
    end
    chk(rx_armed_out, 32'h1);
    apb(1'b0, REG_FIFO_LEVEL, 32'h0);
    chk(rd[6:0], 32'd59);
    peer.load(18, 8'hc0);
    peer.send(18, 1'b1, 0);
    apb(1'b0, REG_FIFO_LEVEL, 32'h0);
    chk(rd[6:0], 32'd64);
    apb(1'b0, REG_ERROR, 32'h0);
    chk(rd[ERR_OVFL], 32'h1);
    // host drains the three complete packets
    for (int r = 0; r < 3; r++) begin
      for (int i = 0; i <= row_len[r]; i++) begin
        apb(1'b0, REG_FIFO_DATA, 32'h0);
        exp = (i == 0) ? row_len[r] : (i == row_len[r]) ? {31'h0, ~row_crc[r]} :
          32'(8'(r * 40) + 8'(i));
        chk(rd, exp);
      end
    end
    apb(1'b1, REG_FIFO_LEVEL, 32'h80);
    apb(1'b0, REG_ERROR, 32'h0);
    chk(rd[ERR_OVFL], 32'h0);
    // stop requested in mid packet
    apb(1'b1, REG_CTRL, 32'h41);
    peer.load(18, 8'h10);
    fork
      peer.send(18, 1'b1, 2);
      begin
        repeat (12) @(posedge sys_clk_in);
        apb(1'b1, REG_CTRL, 32'h0);
      end
    join
    repeat (4) @(posedge sys_clk_in);
    apb(1'b0, REG_FIFO_LEVEL, 32'h0);
    chk({rx_armed_out, rd[6:0]}, 32'd19);
    apb(1'b1, REG_FIFO_LEVEL, 32'h80);
    // field detector, threshold 8
    apb(1'b1, REG_CTRL, 32'h800);
    rf_level_in <= 4'h7;
    repeat (3) @(posedge sys_clk_in);
    chk(field_present_out, 32'h0);
    rf_level_in <= 4'h8;
    cnt = 0;
    for (int k = 0; k < 6; k++) begin
      @(posedge sys_clk_in);
      #1;
      if (field_wake_out === 1'b1) cnt++;
    end
    chk({field_present_out, 8'(cnt)}, 32'h101);
    apb(1'b1, REG_CTRL, 32'h820);
    repeat (2) @(posedge sys_clk_in);
    chk(amp_on_out, 32'h1);
    apb(1'b1, REG_CTRL, 32'h830);
    repeat (2) @(posedge sys_clk_in);
    chk(amp_on_out, 32'h0);
    // timer over slots 0..2, every slot then last only
    apb(1'b1, REG_SLOTS, 32'h2);
    for (int m = 0; m < 2; m++) begin
      apb(1'b1, REG_CTRL, 32'h880 | (m << CTRL_TMR_LAST));
      cnt = 0;
      for (int k = 0; k < 60; k++) begin
        @(posedge sys_clk_in);
        #1;
        if (timer_event_out === 1'b1) cnt++;
      end
      chk({timer_running_out, 8'(cnt)}, (m == 1) ? 32'h1 : 32'h3);
    end
    // target mode: polling with several system codes
    apb(1'b1, REG_SYS_CODE, 32'h1234);
    apb(1'b1, REG_CTRL, 32'h402);
    repeat (2) @(posedge sys_clk_in);
    chk({auto_anticollision_command_active_out, mode_det_active_out}, 32'h3);
    for (int j = 0; j < 6; j++) begin
      peer.load(6, 8'h00);
      peer.frame[1] = POLL_CMD;
      peer.frame[2] = sc_tab[j][15:8];
      peer.frame[3] = sc_tab[j][7:0];
      peer.frame[5] = 8'h03;
      peer.send(6, 1'b1, 1);
      wresp(got, slot);
      chk(got, (j < 4) ? 32'h1 : 32'h0);
      chk(slot <= 8'h03, 32'h1);
    end
    @(posedge sys_clk_in);
    det_valid_in <= 1'b1;
    det_scheme_in <= 2'h1;
    det_rate_in <= 2'h2;
    @(posedge sys_clk_in);
    det_scheme_in <= 2'h0;
    det_rate_in <= RATE_RSVD;
    @(posedge sys_clk_in);
    det_valid_in <= 1'b0;
    repeat (2) @(posedge sys_clk_in);
    chk({mode_locked_out, rx_scheme_out, rx_rate_out}, 32'h16);
    rf_level_in <= 4'h0;
    repeat (4) @(posedge sys_clk_in);
    chk(mode_locked_out, 32'h0);
    rf_level_in <= 4'h8;
    apb(1'b1, REG_CTRL, 32'h406);
    repeat (2) @(posedge sys_clk_in);
    chk(mode_det_active_out, 32'h0);
    // another command ends the anticollision run and is kept
    peer.load(8, 8'h20);
    peer.frame[1] = 8'h06;
    peer.send(8, 1'b1, 1);
    wresp(got, slot);
    chk({8'(got), auto_anticollision_command_active_out}, 32'h0);
    apb(1'b0, REG_FIFO_LEVEL, 32'h0);
    chk(rd[6:0], 32'd9);
    apb(1'b0, REG_FIFO_DATA, 32'h0);
    chk(rd, 32'd8);
    summarize();
  end
endmodule
